/* File: dv/motor_command_data_selector_tb.sv */
// Testbench for the motor command data selector: one task per scenario.
// Assumes a 25 MHz core clock; the controller model drives run and select pins.
`timescale 1ns/1ps
module motor_command_data_selector_tb;
  logic clk = 1'b0, rst = 1'b1, forward_run_in, reverse_run_in, dsel, three = 1'b0, ramp_set = 1'b0;
  logic [3:0] sel, sel_asg = 4'hF, d_addr = 4'h0, dnum;
  logic [1:0] tle = 2'h0, tle_asg = 2'h0;
  logic map_we = 1'b0, map_in = 1'b0, g_we = 1'b0, o_we = 1'b0, m_we = 1'b0, d_we = 1'b0;
  logic [8:0] g_in = 9'h000, m_in = 9'h000, mtq = 9'h000, tlim, gain, tmax;
  logic signed [8:0] o_in = 9'h000, ofs;
  logic [7:0] dv = 8'h00;
  logic [12:0] aspd = 13'h0000, spd;
  logic pmode = 1'b0, pkey = 1'b0, dir_cw, running, reached, unstable, dmap, blink;
  motor_cmd_pkg::cmd_src_e src = motor_cmd_pkg::SRC_DIGITAL;
  motor_cmd_pkg::op_data_s d_data = '0;
  int num_errors = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  run_select_controller u_run_select_controller (
    .clk(clk), .forward_run_in(forward_run_in), .reverse_run_in(reverse_run_in), .dir_sel(dsel), .sel(sel));

  motor_command_data_selector u_motor_command_data_selector (
    .CORE_CLK(clk), .RESET(rst), .FORWARD_RUN_IN(forward_run_in), .REVERSE_RUN_IN(reverse_run_in),
    .DIRECTION_SELECT_IN(dsel), .DATA_SELECT_IN(sel), .DATA_SELECT_ASSIGNED(sel_asg),
    .TORQUE_LIMIT_ENABLE_IN(tle), .TORQUE_LIMIT_ENABLE_ASSIGNED(tle_asg),
    .THREE_WIRE_MODE(three), .DIR_MAP_WE(map_we), .DIR_MAP_IN(map_in),
    .RAMP_TO_SET_SPEED(ramp_set), .CMD_SOURCE(src), .GAIN_WE(g_we), .GAIN_IN(g_in),
    .OFFSET_WE(o_we), .OFFSET_IN(o_in), .TQ_MAX_WE(m_we), .TQ_MAX_IN(m_in),
    .DATA_WE(d_we), .DATA_WADDR(d_addr), .DATA_WDATA(d_data), .ANALOG_DV(dv),
    .ANALOG_SPEED_RPM(aspd), .MOTOR_TORQUE_PCT(mtq), .PANEL_MODE(pmode),
    .PANEL_DIR_KEY(pkey), .SPEED_CMD_RPM(spd), .DIRECTION_CW(dir_cw), .RUNNING(running),
    .TORQUE_LIMIT_PCT(tlim), .TORQUE_LIMIT_REACHED_OUT(reached),
    .TORQUE_LIMIT_UNSTABLE(unstable), .DATA_NUMBER(dnum), .GAIN_PCT_PER_V(gain),
    .OFFSET_PCT(ofs), .TQ_MAX_PCT(tmax), .DIR_MAP(dmap), .PANEL_DIR_BLINK(blink));

  task automatic summarize();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
  endtask : do_reset

  function automatic logic cond(input int w);
    return (w == 0) ? (running === 1'b1) : (w == 1) ? (running === 1'b0) : (spd !== 13'h0000);
  endfunction : cond

  task automatic await(input int w, input int lim);
    int i;
    for (i = 0; i < lim && !cond(w); i++) begin
      @(negedge clk);
    end
    if (!cond(w)) begin
      $display("CHECK FAILED wait %0d expected 1 seen 0", w);
      num_errors++;
      summarize();
    end
  endtask : await

  // Parameter write: 0 gain, 1 offset, 2 maximum, 3 direction mapping
  task automatic wr(input int k, input logic [8:0] v);
    @(negedge clk);
    {g_in, o_in, m_in, map_in} = {v, v, v, v[0]};
    {g_we, o_we, m_we, map_we} = 4'h8 >> k;
    @(negedge clk);
    {g_we, o_we, m_we, map_we} = 4'h0;
    @(negedge clk);
  endtask : wr

  task automatic wdata(input logic [3:0] a, input logic [12:0] s, input logic [8:0] t);
    @(negedge clk);
    d_addr = a;
    d_data = {s, t, 8'h05, 8'h05};
    d_we = 1'b1;
    @(negedge clk);
    d_we = 1'b0;
  endtask : wdata

  task automatic t_params();
    do_reset();
    check("gain", gain, 16'h0041);
    check("offset", {7'h00, ofs}, 16'h0000);
    check("max", tmax, 16'h012C);
    check("map", dmap, 16'h0001);
    wr(0, 9'h12C);
    wr(0, 9'h12D);
    check("gain", gain, 16'h012C);
    wr(1, 9'h16A);
    wr(1, 9'h169);
    check("offset", {7'h00, ofs}, 16'h016A);
    wr(1, 9'h097);
    check("offset", {7'h00, ofs}, 16'h016A);
    wr(2, 9'h000);
    wr(2, 9'h12D);
    check("max", tmax, 16'h0000);
  endtask : t_params

  task automatic t_select();
    int i;
    do_reset();
    for (i = 0; i < 16; i++) begin
      u_run_select_controller.drive(1'b0, 1'b0, 1'b0, 4'(i), 8);
      check("data number", dnum, 16'(i));
    end
    sel_asg = 4'h3;
    u_run_select_controller.drive(1'b0, 1'b0, 1'b0, 4'hE, 8);
    check("data number", dnum, 16'h0002);
    sel_asg = 4'hF;
  endtask : t_select

  task automatic t_torque();
    do_reset();
    wdata(4'h5, 13'h03E8, 9'h078);
    u_run_select_controller.drive(1'b1, 1'b0, 1'b0, 4'h5, 8);
    check("limit", tlim, 16'h0078);
    tle_asg = 2'h1;
    cyc(8);
    check("limit", tlim, 16'h012C);
    tle_asg = 2'h3;
    tle = 2'h1;
    cyc(8);
    check("limit", tlim, 16'h012C);
    tle = 2'h3;
    cyc(8);
    check("limit", tlim, 16'h0078);
    mtq = 9'h077;
    cyc(4);
    check("reached", reached, 16'h0000);
    mtq = 9'h078;
    cyc(4);
    check("reached", reached, 16'h0001);
    wdata(4'h5, 13'h03E8, 9'h013);
    cyc(4);
    check("unstable", unstable, 16'h0001);
    wdata(4'h5, 13'h03E8, 9'h014);
    cyc(4);
    check("unstable", unstable, 16'h0000);
    {mtq, tle, tle_asg} = '0;
  endtask : t_torque

  task automatic analog_case(input logic [8:0] g, o, m, input logic [7:0] v, input logic [8:0] e);
    wr(0, g);
    wr(1, o);
    wr(2, m);
    dv = v;
    cyc(8);
    check("analog limit", tlim, {7'h00, e});
  endtask : analog_case

  task automatic t_analog();
    do_reset();
    src = motor_cmd_pkg::SRC_TORQUE_ANALOG;
    u_run_select_controller.drive(1'b1, 1'b0, 1'b0, 4'h0, 8);
    analog_case(9'h041, 9'h000, 9'h12C, 8'h32, 9'h12C);
    analog_case(9'h020, 9'h00A, 9'h12C, 8'h32, 9'h0AA);
    analog_case(9'h041, 9'h16A, 9'h12C, 8'h14, 9'h000);
    analog_case(9'h014, 9'h000, 9'h0FA, 8'h64, 9'h0C8);
    analog_case(9'h041, 9'h000, 9'h0C8, 8'h32, 9'h0C8);
    src = motor_cmd_pkg::SRC_DIGITAL;
  endtask : t_analog

  // Rows: three-wire, forward, reverse, direction select, mapping, expected CW
  task automatic t_direction();
    logic [5:0] rows [6];
    int i;
    rows = '{6'b010011, 6'b001010, 6'b010000, 6'b110011, 6'b110110, 6'b110000};
    for (i = 0; i < 6; i++) begin
      do_reset();
      three = rows[i][5];
      wr(3, {8'h00, rows[i][1]});
      u_run_select_controller.drive(rows[i][4], rows[i][3], rows[i][2], 4'h0, 2);
      await(0, 20);
      cyc(10);
      check("direction", dir_cw, {15'h0000, rows[i][0]});
    end
    u_run_select_controller.drive(1'b0, 1'b0, 1'b0, 4'h0, 2);
    await(1, 26000);
    check("run", running, 16'h0000);
    three = 1'b0;
    u_run_select_controller.drive(1'b1, 1'b0, 1'b0, 4'h0, 2);
    await(0, 20);
    u_run_select_controller.drive(1'b1, 1'b1, 1'b0, 4'h0, 20);
    check("run", running, 16'h0000);
    u_run_select_controller.drive(1'b0, 1'b0, 1'b0, 4'h0, 2);
  endtask : t_direction

  task automatic t_panel();
    do_reset();
    pmode = 1'b1;
    pkey = 1'b1;
    cyc(8);
    pkey = 1'b0;
    cyc(8);
    check("map", dmap, 16'h0000);
    check("blink", blink, 16'h0000);
    pmode = 1'b0;
  endtask : t_panel

  task automatic ramp_case(input logic to_set, input motor_cmd_pkg::cmd_src_e cs,
                           input logic [3:0] n, input logic [12:0] s, a, input logic [15:0] e);
    do_reset();
    ramp_set = to_set;
    src = cs;
    aspd = a;
    wdata(n, s, 9'h12C);
    u_run_select_controller.drive(1'b1, 1'b0, 1'b0, n, 2);
    await(2, 26000);
    check("speed step", spd, e);
    ramp_set = 1'b0;
    src = motor_cmd_pkg::SRC_DIGITAL;
    u_run_select_controller.drive(1'b0, 1'b0, 1'b0, 4'h0, 2);
  endtask : ramp_case

  initial begin
    cyc(3);
    rst = 1'b0;
    t_params();
    t_select();
    t_torque();
    t_analog();
    t_direction();
    t_panel();
    ramp_case(1'b0, motor_cmd_pkg::SRC_ANALOG_ALL, 4'h0, 13'h0004, 13'h0BB8, 16'h0006);
    ramp_case(1'b1, motor_cmd_pkg::SRC_DIGITAL, 4'h0, 13'h03E8, 13'h0000, 16'h0002);
    ramp_case(1'b0, motor_cmd_pkg::SRC_ANALOG_NO1, 4'h1, 13'h0BB8, 13'h0004, 16'h0004);
    summarize();
  end
endmodule : motor_command_data_selector_tb

/* File: dv/run_select_controller.sv */
// External controller model: drives run, direction and data select pins.
// Assumes the bench calls drive() and that the pins are filtered on the core clock.
`timescale 1ns/1ps
module run_select_controller (
  input  wire logic       clk,
  output logic            forward_run_in,
  output logic            reverse_run_in,
  output logic            dir_sel,
  output logic [3:0]      sel
);
  initial begin
    forward_run_in = 1'b0;
    reverse_run_in = 1'b0;
    dir_sel = 1'b0;
    sel = 4'h0;
  end

  // Changes pins after a falling edge, then holds them for a prompt or slow caller
  task automatic drive(input logic f, input logic r, input logic d, input logic [3:0] s,
                       input int hold);
    @(negedge clk);
    forward_run_in = f;
    reverse_run_in = r;
    dir_sel = d;
    sel = s;
    repeat (hold) @(negedge clk);
  endtask : drive
endmodule : run_select_controller

/* File: rtl/motor_cmd_defines.svh */
// Constants for the motor command data selector: defaults, ranges, ramp timing.
// Assumes CORE_CLK at 25 MHz and a 1 ms ramp tick derived from it.
// Behaviour
// - Raise limit-reached output when torque meets the active limit.
// - Indication below a 20 percent limit may be unstable.
// - Analog limit gain 0 to 300 percent per volt, default 65.
// - Analog limit offset -150 to +150 percent, default zero.
// - Analog limit capped by maximum 0 to 300 percent, default 300.
// - Ramp times 0.0 to 15.0 seconds, default 0.5 seconds.
// - Ramp time spans standstill to rated 3000 r/min.
// - Digital speed may scale ramp time to the selected speed.
// - Direction mapping 0 is CCW positive, 1 is CW, default 1.
// - Two-wire mode: forward run turns the positive direction.
// - Three-wire mode: direction select low turns the positive direction.
// - Four select bits choose one of 16 data sets.
// - Select bits decode as a binary data number.
// - Run with the selected set's speed, limit and ramp times.
// - Run starts on forward or reverse, switches data, stops on release; in three-wire mode only forward starts it, reverse is ignored.
// - Source 1 takes analog speed only for data number 1.
// - Source 2 takes analog speed for every data number.
// - Panel mode blinks direction at standstill; a key toggles it.
// - Limit applies only while limit enable is on, else peak torque.
// - Unassigned enable counts as on; all assigned terminals must be on.
`ifndef MOTOR_CMD_DEFINES_SVH
`define MOTOR_CMD_DEFINES_SVH
`define GAIN_DEFAULT       9'h041
`define GAIN_MAX           9'h12C
`define OFFSET_DEFAULT     9'h000
`define OFFSET_LIMIT       9'h096
`define TQ_MAX_DEFAULT     9'h12C
`define TQ_MAX_LIMIT       9'h12C
`define TQ_PEAK            9'h12C
`define TQ_STABLE_MIN      9'h014
`define RAMP_DEFAULT_DS    8'h05
`define RAMP_MAX_DS        8'h96
`define RATED_RPM          13'h0BB8
`define DIR_DEFAULT        1'b1
`define CLK_HZ             25000000
`define TICK_MS            1
`define TICK_CYCLES        ((`CLK_HZ / 1000) * `TICK_MS)
`define BLINK_TICKS        10'h1F4
`define SYNC_DEPTH         3
`endif

/* File: rtl/motor_cmd_pkg.sv */
// Types for the motor command data selector.
// Assumes the defines header supplies all numeric constants.
package motor_cmd_pkg;
  typedef struct packed {
    logic [12:0] speed_rpm;
    logic [8:0]  torque_pct;
    logic [7:0]  accel_ds;
    logic [7:0]  decel_ds;
  } op_data_s;
  typedef enum logic [1:0] {
    SRC_DIGITAL,
    SRC_ANALOG_NO1,
    SRC_ANALOG_ALL,
    SRC_TORQUE_ANALOG
  } cmd_src_e;
  typedef enum {
    ST_IDLE,
    ST_RUN,
    ST_STOPPING
  } run_state_e;
endpackage : motor_cmd_pkg

/* File: rtl/motor_command_data_selector.sv */
// Command logic: selects data sets, ramps the speed command, derives the torque limit.
// Assumes run and select pins are asynchronous; data table is loaded over a write port.
`timescale 1ns/1ps
`include "motor_cmd_defines.svh"
module motor_command_data_selector (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RESET,
  input  wire logic                      FORWARD_RUN_IN,
  input  wire logic                      REVERSE_RUN_IN,
  input  wire logic                      DIRECTION_SELECT_IN,
  input  wire logic [3:0]                DATA_SELECT_IN,
  input  wire logic [3:0]                DATA_SELECT_ASSIGNED,
  input  wire logic [1:0]                TORQUE_LIMIT_ENABLE_IN,
  input  wire logic [1:0]                TORQUE_LIMIT_ENABLE_ASSIGNED,
  input  wire logic                      THREE_WIRE_MODE,
  input  wire logic                      DIR_MAP_WE,
  input  wire logic                      DIR_MAP_IN,
  input  wire logic                      RAMP_TO_SET_SPEED,
  input  wire motor_cmd_pkg::cmd_src_e   CMD_SOURCE,
  input  wire logic                      GAIN_WE,
  input  wire logic [8:0]                GAIN_IN,
  input  wire logic                      OFFSET_WE,
  input  wire logic signed [8:0]         OFFSET_IN,
  input  wire logic                      TQ_MAX_WE,
  input  wire logic [8:0]                TQ_MAX_IN,
  input  wire logic                      DATA_WE,
  input  wire logic [3:0]                DATA_WADDR,
  input  wire motor_cmd_pkg::op_data_s   DATA_WDATA,
  input  wire logic [7:0]                ANALOG_DV,
  input  wire logic [12:0]               ANALOG_SPEED_RPM,
  input  wire logic [8:0]                MOTOR_TORQUE_PCT,
  input  wire logic                      PANEL_MODE,
  input  wire logic                      PANEL_DIR_KEY,
  output logic [12:0]                    SPEED_CMD_RPM,
  output logic                           DIRECTION_CW,
  output logic                           RUNNING,
  output logic [8:0]                     TORQUE_LIMIT_PCT,
  output logic                           TORQUE_LIMIT_REACHED_OUT,
  output logic                           TORQUE_LIMIT_UNSTABLE,
  output logic [3:0]                     DATA_NUMBER,
  output logic [8:0]                     GAIN_PCT_PER_V,
  output logic signed [8:0]              OFFSET_PCT,
  output logic [8:0]                     TQ_MAX_PCT,
  output logic                           DIR_MAP,
  output logic                           PANEL_DIR_BLINK
);
  localparam int TICK_CYCLES = `TICK_CYCLES;

  // Three-stage synchronisers for the pins
  logic [2:0] fwd_sync_reg;
  logic [2:0] rev_sync_reg;
  logic [2:0] dsel_sync_reg;
  logic [2:0] key_sync_reg;
  logic       fwd_reg, rev_reg, dsel_reg, key_reg;
  wire  [3:0] msel_reg;
  wire  [1:0] tle_reg;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      fwd_sync_reg  <= 3'h0;
      rev_sync_reg  <= 3'h0;
      dsel_sync_reg <= 3'h0;
      key_sync_reg  <= 3'h0;
    end else begin
      fwd_sync_reg  <= {fwd_sync_reg[1:0], FORWARD_RUN_IN};
      rev_sync_reg  <= {rev_sync_reg[1:0], REVERSE_RUN_IN};
      dsel_sync_reg <= {dsel_sync_reg[1:0], DIRECTION_SELECT_IN};
      key_sync_reg  <= {key_sync_reg[1:0], PANEL_DIR_KEY};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_msel
      logic [2:0] sync_reg;
      logic       level_reg;
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          sync_reg  <= 3'h0;
          level_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[1:0], DATA_SELECT_IN[gi]};
          if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
          end
        end
      end
      assign msel_reg[gi] = level_reg;
    end
    for (gi = 0; gi < 2; gi++) begin : g_tle
      logic [2:0] sync_reg;
      logic       level_reg;
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          sync_reg  <= 3'h0;
          level_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[1:0], TORQUE_LIMIT_ENABLE_IN[gi]};
          if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
          end
        end
      end
      assign tle_reg[gi] = level_reg;
    end
  endgenerate

  // Filtered levels: change accepted once stages two and three agree
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      fwd_reg  <= 1'b0;
      rev_reg  <= 1'b0;
      dsel_reg <= 1'b0;
      key_reg  <= 1'b0;
    end else begin
      if (fwd_sync_reg[1] == fwd_sync_reg[2]) fwd_reg <= fwd_sync_reg[2];
      if (rev_sync_reg[1] == rev_sync_reg[2]) rev_reg <= rev_sync_reg[2];
      if (dsel_sync_reg[1] == dsel_sync_reg[2]) dsel_reg <= dsel_sync_reg[2];
      if (key_sync_reg[1] == key_sync_reg[2]) key_reg <= key_sync_reg[2];
    end
  end

  // Parameter registers
  logic [8:0]        gain_reg;
  logic signed [8:0] offset_reg;
  logic [8:0]        tq_max_reg;
  logic              dir_map_reg;
  logic              key_prev_reg;
  wire               key_press = key_reg & ~key_prev_reg;
  wire               stopped;
  wire               gain_ok   = (GAIN_IN <= `GAIN_MAX);
  wire               offset_ok = (OFFSET_IN <= $signed(`OFFSET_LIMIT)) &&
                                 (OFFSET_IN >= -$signed(`OFFSET_LIMIT));
  wire               tq_max_ok = (TQ_MAX_IN <= `TQ_MAX_LIMIT);

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      gain_reg     <= `GAIN_DEFAULT;
      offset_reg   <= `OFFSET_DEFAULT;
      tq_max_reg   <= `TQ_MAX_DEFAULT;
      dir_map_reg  <= `DIR_DEFAULT;
      key_prev_reg <= 1'b0;
    end else begin
      key_prev_reg <= key_reg;
      if (GAIN_WE && gain_ok) gain_reg <= GAIN_IN;
      if (OFFSET_WE && offset_ok) offset_reg <= OFFSET_IN;
      if (TQ_MAX_WE && tq_max_ok) tq_max_reg <= TQ_MAX_IN;
      if (DIR_MAP_WE) begin
        dir_map_reg <= DIR_MAP_IN;
      end else if (PANEL_MODE && stopped && key_press) begin
        dir_map_reg <= ~dir_map_reg;
      end
    end
  end

  // Operation data table, ramp fields clipped to range
  motor_cmd_pkg::op_data_s data_mem [16];
  motor_cmd_pkg::op_data_s wdata_clip;
  always_comb begin
    wdata_clip = DATA_WDATA;
    if (DATA_WDATA.accel_ds > `RAMP_MAX_DS) wdata_clip.accel_ds = `RAMP_MAX_DS;
    if (DATA_WDATA.decel_ds > `RAMP_MAX_DS) wdata_clip.decel_ds = `RAMP_MAX_DS;
  end
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 16; i++) data_mem[i] <= '{speed_rpm: 13'h0000, torque_pct: `TQ_PEAK,
                                                     accel_ds: `RAMP_DEFAULT_DS,
                                                     decel_ds: `RAMP_DEFAULT_DS};
    end else if (DATA_WE) begin
      data_mem[DATA_WADDR] <= wdata_clip;
    end
  end

  // Data number from assigned select bits
  wire [3:0] data_num = msel_reg & DATA_SELECT_ASSIGNED;
  motor_cmd_pkg::op_data_s sel_data;
  assign sel_data = data_mem[data_num];

  // Speed target source
  wire use_analog = (CMD_SOURCE == motor_cmd_pkg::SRC_ANALOG_ALL) ||
                    (CMD_SOURCE == motor_cmd_pkg::SRC_ANALOG_NO1 && data_num == 4'h1);
  wire [12:0] set_speed = use_analog ? ANALOG_SPEED_RPM : sel_data.speed_rpm;

  // Run state and direction
  motor_cmd_pkg::run_state_e state_reg, state_next;
  logic        dir_cw_reg;
  logic [12:0] speed_reg;
  wire         run_req = fwd_reg ^ rev_reg;
  wire         req_pos = THREE_WIRE_MODE ? ~dsel_reg : fwd_reg;
  wire         req_cw  = req_pos ? dir_map_reg : ~dir_map_reg;
  wire         run_act = THREE_WIRE_MODE ? fwd_reg : run_req;
  assign stopped = (state_reg == motor_cmd_pkg::ST_IDLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      motor_cmd_pkg::ST_IDLE:     if (run_act) state_next = motor_cmd_pkg::ST_RUN;
      motor_cmd_pkg::ST_RUN:      if (!run_act) state_next = motor_cmd_pkg::ST_STOPPING;
      motor_cmd_pkg::ST_STOPPING: if (run_act) state_next = motor_cmd_pkg::ST_RUN;
                                  else if (speed_reg == 13'h0000) state_next = motor_cmd_pkg::ST_IDLE;
    endcase
  end

  // Ramp: step per ms = reference speed / (time in ms)
  logic [15:0] tick_cnt_reg;
  wire         tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
  wire         rev_needed = (state_reg != motor_cmd_pkg::ST_IDLE) && (req_cw != dir_cw_reg);
  wire [12:0]  target = (state_reg == motor_cmd_pkg::ST_RUN && !rev_needed) ? set_speed : 13'h0000;
  wire         accel = target > speed_reg;
  wire [7:0]   ramp_ds = accel ? sel_data.accel_ds : sel_data.decel_ds;
  wire [12:0]  ref_rpm = (RAMP_TO_SET_SPEED && !use_analog) ? set_speed : `RATED_RPM;
  wire [19:0]  ramp_ms = 20'(ramp_ds) * 20'h00064;
  wire [19:0]  step_raw = (ramp_ms == 20'h0) ? 20'h01FFF : 20'(ref_rpm) / ramp_ms;
  wire [12:0]  step = (step_raw == 20'h0) ? 13'h0001 :
                      (step_raw > 20'h01FFF) ? 13'h1FFF : step_raw[12:0];
  wire [12:0]  diff = accel ? (target - speed_reg) : (speed_reg - target);
  wire [12:0]  speed_next = (diff <= step) ? target :
                            accel ? (speed_reg + step) : (speed_reg - step);

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= motor_cmd_pkg::ST_IDLE;
      tick_cnt_reg <= 16'h0000;
      speed_reg    <= 13'h0000;
      dir_cw_reg   <= `DIR_DEFAULT;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (tick) speed_reg <= speed_next;
      if (speed_reg == 13'h0000 && run_act) dir_cw_reg <= req_cw;
      else if (stopped) dir_cw_reg <= req_cw;
    end
  end

  // Torque limit, analog path: gain * dV/10 + offset, clamped
  logic signed [20:0] an_raw;
  logic [8:0]         an_limit;
  always_comb begin
    an_raw = 21'(($signed({1'b0, gain_reg}) * $signed({1'b0, ANALOG_DV})) / 10)
             + 21'(offset_reg);
    if (an_raw < 0) an_limit = 9'h000;
    else if (an_raw > $signed({12'h000, tq_max_reg})) an_limit = tq_max_reg;
    else an_limit = an_raw[8:0];
  end
  wire [8:0] set_limit = (CMD_SOURCE == motor_cmd_pkg::SRC_TORQUE_ANALOG) ? an_limit
                                                                          : sel_data.torque_pct;
  wire tle_all = &(tle_reg | ~TORQUE_LIMIT_ENABLE_ASSIGNED);
  wire [8:0] act_limit = tle_all ? set_limit : `TQ_PEAK;

  // Blink counter for panel direction display
  logic [9:0] blink_cnt_reg;
  logic       blink_reg;
  logic       reached_reg;
  logic [8:0] limit_reg;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      blink_cnt_reg <= 10'h000;
      blink_reg     <= 1'b0;
      reached_reg   <= 1'b0;
      limit_reg     <= `TQ_PEAK;
    end else begin
      limit_reg   <= act_limit;
      reached_reg <= (MOTOR_TORQUE_PCT >= act_limit);
      if (!(PANEL_MODE && stopped)) begin
        blink_cnt_reg <= 10'h000;
        blink_reg     <= 1'b0;
      end else if (tick) begin
        if (blink_cnt_reg == `BLINK_TICKS - 10'h001) begin
          blink_cnt_reg <= 10'h000;
          blink_reg     <= ~blink_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 10'h001;
        end
      end
    end
  end

  assign SPEED_CMD_RPM            = speed_reg;
  assign DIRECTION_CW             = dir_cw_reg;
  assign RUNNING                  = ~stopped;
  assign TORQUE_LIMIT_PCT         = limit_reg;
  assign TORQUE_LIMIT_REACHED_OUT = reached_reg;
  assign TORQUE_LIMIT_UNSTABLE    = (limit_reg < `TQ_STABLE_MIN);
  assign DATA_NUMBER              = data_num;
  assign GAIN_PCT_PER_V           = gain_reg;
  assign OFFSET_PCT               = offset_reg;
  assign TQ_MAX_PCT               = tq_max_reg;
  assign DIR_MAP                  = dir_map_reg;
  assign PANEL_DIR_BLINK          = blink_reg;

  // Checks on outputs and the command path
  a_reached_follows: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (MOTOR_TORQUE_PCT >= act_limit) |=> TORQUE_LIMIT_REACHED_OUT)
    else $error("limit reached not raised");
  a_reached_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (MOTOR_TORQUE_PCT < act_limit) |=> !TORQUE_LIMIT_REACHED_OUT)
    else $error("limit reached not cleared");
  a_unstable_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    TORQUE_LIMIT_UNSTABLE == (TORQUE_LIMIT_PCT < 9'h014))
    else $error("unstable flag wrong");
  a_gain_range: assert property (@(posedge CORE_CLK) disable iff (RESET)
    gain_reg <= 9'h12C)
    else $error("gain out of range");
  a_offset_range: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (offset_reg <= 9'sd150) && (offset_reg >= -9'sd150))
    else $error("offset out of range");
  a_analog_capped: assert property (@(posedge CORE_CLK) disable iff (RESET)
    an_limit <= tq_max_reg)
    else $error("analog limit above maximum");
  a_ramp_range: assert property (@(posedge CORE_CLK) disable iff (RESET)
    sel_data.accel_ds <= 8'h96 && sel_data.decel_ds <= 8'h96)
    else $error("ramp time out of range");
  a_peak_disabled: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !tle_all |=> TORQUE_LIMIT_PCT == 9'h12C)
    else $error("peak torque not applied");
  a_limit_applied: assert property (@(posedge CORE_CLK) disable iff (RESET)
    tle_all |=> TORQUE_LIMIT_PCT == $past(set_limit))
    else $error("set limit not applied");
  a_analog_all: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CMD_SOURCE == motor_cmd_pkg::SRC_ANALOG_ALL |-> set_speed == ANALOG_SPEED_RPM)
    else $error("analog speed not used");
  a_analog_no1: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (CMD_SOURCE == motor_cmd_pkg::SRC_ANALOG_NO1 && data_num != 4'h1) |->
    set_speed == sel_data.speed_rpm)
    else $error("stored speed not used");
  a_stop_release: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (state_reg == motor_cmd_pkg::ST_RUN && !run_act) |=>
    state_reg == motor_cmd_pkg::ST_STOPPING)
    else $error("no stop on release");
  a_both_run_stop: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (!THREE_WIRE_MODE && fwd_reg && rev_reg && state_reg == motor_cmd_pkg::ST_RUN) |=>
    state_reg == motor_cmd_pkg::ST_STOPPING)
    else $error("no stop on both run inputs");
  a_idle_speed: assert property (@(posedge CORE_CLK) disable iff (RESET)
    state_reg == motor_cmd_pkg::ST_IDLE |-> speed_reg == 13'h0000)
    else $error("idle with nonzero speed");
  a_dir_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
    speed_reg != 13'h0000 |=> $stable(dir_cw_reg))
    else $error("direction changed while turning");
  a_blink_idle: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !(PANEL_MODE && stopped) |=> !PANEL_DIR_BLINK)
    else $error("blink outside panel standstill");
  a_ramp_step: assert property (@(posedge CORE_CLK) disable iff (RESET)
    tick |=> (SPEED_CMD_RPM - $past(SPEED_CMD_RPM) <= $past(step)) ||
             ($past(SPEED_CMD_RPM) - SPEED_CMD_RPM <= $past(step)))
    else $error("ramp step too large");
endmodule : motor_command_data_selector
